// *** qmr_pkg.sv ***
// package: register map, field layout and reset values of the region slice
package qmr_pkg;
	// bus geometry
	localparam int ADDR_W      = 12;
	localparam int NUM_REGIONS = 16;
	localparam int NUM_QUEUES  = 96;
	localparam int PEND_WORDS  = 6;
	// flat register byte addresses
	localparam logic [11:0] OFS_LINK1_BASE_HIGH = 12'h000;
	localparam logic [11:0] OFS_PENDING_WORD0   = 12'h004;
	// region block: base + 16 * region + 4 * word
	localparam logic [3:0]  REGION_PAGE         = 4'h1;
	localparam logic [1:0]  SUB_BASE_LOW        = 2'h0;
	localparam logic [1:0]  SUB_BASE_HIGH       = 2'h1;
	localparam logic [1:0]  SUB_CONFIG_A        = 2'h2;
	localparam logic [1:0]  SUB_CONFIG_B        = 2'h3;
	// field positions and writable masks
	localparam int DESC_CODE_LSB  = 8;
	localparam int DESC_CODE_MSB  = 11;
	localparam int REG_SIZE_LSB   = 0;
	localparam int REG_SIZE_MSB   = 2;
	localparam int START_IDX_MSB  = 13;
	localparam logic [15:0] CONFIG_A_MASK = 16'h0f07;
	localparam logic [15:0] CONFIG_B_MASK = 16'h3fff;
	localparam logic [3:0]  DESC_CODE_MAX      = 4'h8;
	// decoded sizes
	localparam logic [13:0] DESC_BYTES_MIN = 14'h0020;
	localparam logic [12:0] REG_COUNT_MIN  = 13'h0020;
	// reset values
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// full 16-bit word needs both low byte lanes
	localparam logic [1:0] WORD_STRB   = 2'b11;
endpackage

// *** qmr_regs.sv ***
// module: queue manager region and pending register slice, AXI4-Lite slave
//
// Contract
// - writable upper half of link region 1 base
// - six read-only pending words, sixteen queues each
// - only full 16-bit word accesses accepted
// - sixteen descriptor regions, each with base
// - region base split into low, high words
// - region holds count descriptors of one size
// - two config words per region, mixed access
// - descriptor size code bits 11:8, 32..8K
// - region size code bits 2:0, 32..4K
// - start index bits 13:0 in config b
`timescale 1ns/1ns
module qmr_regs (
	input  wire logic                         CLK,
	input  wire logic                         RST_N,
	input  wire logic [qmr_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire logic                         S_AXI_AWVALID,
	output logic                              S_AXI_AWREADY,
	input  wire logic [31:0]                  S_AXI_WDATA,
	input  wire logic [3:0]                   S_AXI_WSTRB,
	input  wire logic                         S_AXI_WVALID,
	output logic                              S_AXI_WREADY,
	output logic [1:0]                        S_AXI_BRESP,
	output logic                              S_AXI_BVALID,
	input  wire logic                         S_AXI_BREADY,
	input  wire logic [qmr_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
	input  wire logic                         S_AXI_ARVALID,
	output logic                              S_AXI_ARREADY,
	output logic [31:0]                       S_AXI_RDATA,
	output logic [1:0]                        S_AXI_RRESP,
	output logic                              S_AXI_RVALID,
	input  wire logic                         S_AXI_RREADY,
	input  wire logic [qmr_pkg::NUM_QUEUES-1:0] QUEUE_PENDING,
	input  wire logic [3:0]                   REGION_SEL,
	output logic [15:0]                       LINK1_BASE_HIGH,
	output logic [31:0]                       REGION_BASE,
	output logic [13:0]                       DESC_BYTES,
	output logic                              DESC_CODE_RESERVED,
	output logic [12:0]                       REGION_DESC_COUNT,
	output logic [13:0]                       REGION_START_INDEX
);
	import qmr_pkg::*;

	typedef struct packed {
		logic                  aw_hold;
		logic [ADDR_W-1:0]     aw_addr;
		logic                  w_hold;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [15:0]           link1_hi;
		logic [NUM_REGIONS-1:0][15:0] base_lo;
		logic [NUM_REGIONS-1:0][15:0] base_hi;
		logic [NUM_REGIONS-1:0][15:0] cfg_a;
		logic [NUM_REGIONS-1:0][15:0] cfg_b;
		logic [31:0]           reg_base;
		logic [13:0]           desc_bytes;
		logic                  size_bad;
		logic [12:0]           desc_count;
		logic [13:0]           start_idx;
	} qmr_state_s;

	qmr_state_s st;
	qmr_state_s next_st;

	// ------------------------------------------------------------
	// handshake outputs
	// ------------------------------------------------------------
	// address and data taken in either order, one write at a time
	assign S_AXI_AWREADY = !st.aw_hold && !st.bvalid;
	assign S_AXI_WREADY  = !st.w_hold && !st.bvalid;
	assign S_AXI_ARREADY = !st.rvalid;
	assign S_AXI_BVALID  = st.bvalid;
	assign S_AXI_BRESP   = st.bresp;
	assign S_AXI_RVALID  = st.rvalid;
	assign S_AXI_RDATA   = st.rdata;
	assign S_AXI_RRESP   = st.rresp;
	// dma-facing side, all straight from flops
	assign LINK1_BASE_HIGH    = st.link1_hi;
	assign REGION_BASE        = st.reg_base;
	assign DESC_BYTES         = st.desc_bytes;
	assign DESC_CODE_RESERVED = st.size_bad;
	assign REGION_DESC_COUNT  = st.desc_count;
	assign REGION_START_INDEX = st.start_idx;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// write commit, read decode and region lookup in one pass
	always_comb begin
		logic [ADDR_W-1:0] wa;
		logic [ADDR_W-1:0] ra;
		logic [3:0]        wr_r;
		logic [3:0]        rd_r;
		logic [15:0]       wd;
		logic [3:0]        dcode;
		logic [2:0]        scode;
		logic              ok;
		logic [2:0]        pidx;
		next_st = st;
		wa    = st.aw_addr;
		ra    = S_AXI_ARADDR;
		wr_r  = wa[7:4];
		rd_r  = ra[7:4];
		wd    = st.w_data[15:0];
		dcode = 4'h0;
		scode = 3'h0;
		ok    = 1'b0;
		pidx  = 3'h0;

		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_st.w_hold = 1'b1;
			next_st.w_data = S_AXI_WDATA;
			next_st.w_strb = S_AXI_WSTRB;
		end
		if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end

		// commit once both halves are held; partial lanes are refused
		if (st.aw_hold && st.w_hold && !st.bvalid) begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold  = 1'b0;
			next_st.bvalid  = 1'b1;
			ok = (st.w_strb[1:0] == WORD_STRB);
			if (!ok) begin
				ok = 1'b0;
			end else if (wa == OFS_LINK1_BASE_HIGH) begin
				next_st.link1_hi = wd;
			end else if (wa[11:8] == REGION_PAGE && wa[1:0] == 2'b00) begin
				if (wa[3:2] == SUB_BASE_LOW) begin
					next_st.base_lo[wr_r] = wd;
				end else if (wa[3:2] == SUB_BASE_HIGH) begin
					next_st.base_hi[wr_r] = wd;
				end else if (wa[3:2] == SUB_CONFIG_A) begin
					// reserved bits stay zero
					next_st.cfg_a[wr_r] = wd & CONFIG_A_MASK;
				end else begin
					next_st.cfg_b[wr_r] = wd & CONFIG_B_MASK;
				end
			end else begin
				ok = 1'b0; // pending words and holes refuse writes
			end
			next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
		end

		if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		// read data latched at acceptance, upper half reads zero
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			next_st.rdata  = 32'h0000_0000;
			pidx = 3'(ra[4:2] - 3'h1);
			if (ra == OFS_LINK1_BASE_HIGH) begin
				next_st.rdata[15:0] = st.link1_hi;
			end else if (ra[11:5] == 7'h00 && ra[1:0] == 2'b00
					&& pidx < 3'(PEND_WORDS)) begin
				// word k carries queues 16k+15..16k
				next_st.rdata[15:0] = QUEUE_PENDING[16*pidx +: 16];
			end else if (ra[11:8] == REGION_PAGE && ra[1:0] == 2'b00) begin
				if (ra[3:2] == SUB_BASE_LOW) begin
					next_st.rdata[15:0] = st.base_lo[rd_r];
				end else if (ra[3:2] == SUB_BASE_HIGH) begin
					next_st.rdata[15:0] = st.base_hi[rd_r];
				end else if (ra[3:2] == SUB_CONFIG_A) begin
					next_st.rdata[15:0] = st.cfg_a[rd_r];
				end else begin
					next_st.rdata[15:0] = st.cfg_b[rd_r];
				end
			end else begin
				next_st.rresp = RESP_SLVERR;
			end
		end

		// region lookup for the dma side, one cycle behind the select
		dcode = st.cfg_a[REGION_SEL][DESC_CODE_MSB:DESC_CODE_LSB];
		scode = st.cfg_a[REGION_SEL][REG_SIZE_MSB:REG_SIZE_LSB];
		next_st.reg_base = {st.base_hi[REGION_SEL],
			st.base_lo[REGION_SEL]};
		// reserved size codes give zero bytes and a flag
		next_st.size_bad   = dcode > DESC_CODE_MAX;
		next_st.desc_bytes = next_st.size_bad ? 14'h0000
			: DESC_BYTES_MIN << dcode;
		next_st.desc_count = REG_COUNT_MIN << scode;
		next_st.start_idx  =
			st.cfg_b[REGION_SEL][START_IDX_MSB:0];
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// every register clears to zero, regions start unconfigured
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	logic [11:0] ast_wa;
	assign ast_wa = st.aw_addr;

	sequence s_commit;
		st.aw_hold && st.w_hold && !st.bvalid;
	endsequence

	sequence s_full_commit;
		s_commit ##0 (st.w_strb[1:0] == WORD_STRB);
	endsequence

	sequence s_read_take;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence

	property p_link1_write;
		s_full_commit ##0 (ast_wa == OFS_LINK1_BASE_HIGH) |=>
			LINK1_BASE_HIGH == $past(st.w_data[15:0]) &&
			S_AXI_BVALID && S_AXI_BRESP == RESP_OKAY;
	endproperty
	a_link1_write: assert property (p_link1_write)
		else $error("link region 1 high word not stored");

	property p_pending_word0;
		s_read_take ##0 (S_AXI_ARADDR == OFS_PENDING_WORD0) |=>
			S_AXI_RVALID && S_AXI_RDATA == {16'h0000,
			$past(QUEUE_PENDING[15:0])};
	endproperty
	a_pending_word0: assert property (p_pending_word0)
		else $error("pending word 0 wrong");

	property p_pending_word5;
		s_read_take ##0 (S_AXI_ARADDR == 12'h018) |=>
			S_AXI_RDATA[15:0] == $past(QUEUE_PENDING[95:80]);
	endproperty
	a_pending_word5: assert property (p_pending_word5)
		else $error("pending word 5 wrong");

	property p_partial_refused;
		s_commit ##0 (st.w_strb[1:0] != WORD_STRB) |=>
			S_AXI_BRESP == RESP_SLVERR && $stable(st.link1_hi)
			&& $stable(st.cfg_a) && $stable(st.base_lo);
	endproperty
	a_partial_refused: assert property (p_partial_refused)
		else $error("byte-wide write not refused");

	property p_base_low_write;
		s_full_commit ##0 (ast_wa[11:8] == REGION_PAGE &&
			ast_wa[3:0] == 4'h0) |=>
			st.base_lo[$past(ast_wa[7:4])] == $past(st.w_data[15:0]);
	endproperty
	a_base_low_write: assert property (p_base_low_write)
		else $error("region base low not stored");

	property p_region_base;
		$stable(REGION_SEL) && $stable(st.base_hi) ##1
			$stable(st.base_lo) |=> REGION_BASE ==
			{$past(st.base_hi[REGION_SEL]),
			$past(st.base_lo[REGION_SEL])};
	endproperty
	a_region_base: assert property (p_region_base)
		else $error("region base not joined from two words");

	property p_desc_bytes;
		st.cfg_a[REGION_SEL][11:8] <= DESC_CODE_MAX |=>
			!DESC_CODE_RESERVED && DESC_BYTES ==
			14'(14'h0020 << $past(st.cfg_a[REGION_SEL][11:8]));
	endproperty
	a_desc_bytes: assert property (p_desc_bytes)
		else $error("descriptor size decode wrong");

	property p_desc_reserved;
		st.cfg_a[REGION_SEL][11:8] > DESC_CODE_MAX |=>
			DESC_CODE_RESERVED && DESC_BYTES == 14'h0000;
	endproperty
	a_desc_reserved: assert property (p_desc_reserved)
		else $error("reserved size code not flagged");

	property p_region_count;
		1'b1 |=> REGION_DESC_COUNT ==
			13'(13'h0020 << $past(st.cfg_a[REGION_SEL][2:0]));
	endproperty
	a_region_count: assert property (p_region_count)
		else $error("region count decode wrong");

	property p_config_b_write;
		s_full_commit ##0 (ast_wa[11:8] == REGION_PAGE &&
			ast_wa[3:0] == 4'hc) |=>
			st.cfg_b[$past(ast_wa[7:4])] ==
			($past(st.w_data[15:0]) & CONFIG_B_MASK);
	endproperty
	a_config_b_write: assert property (p_config_b_write)
		else $error("start index not stored");

	property p_config_a_read;
		s_read_take ##0 (S_AXI_ARADDR[11:8] == REGION_PAGE &&
			S_AXI_ARADDR[3:0] == 4'h8) |=>
			(S_AXI_RDATA[15:0] & ~CONFIG_A_MASK) == 16'h0000 &&
			S_AXI_RDATA[15:0] == $past(st.cfg_a[S_AXI_ARADDR[7:4]]);
	endproperty
	a_config_a_read: assert property (p_config_a_read)
		else $error("config a readback wrong");

	property p_base_high_write;
		s_full_commit ##0 (ast_wa[11:8] == REGION_PAGE &&
			ast_wa[3:0] == 4'h4) |=>
			st.base_hi[$past(ast_wa[7:4])] == $past(st.w_data[15:0]);
	endproperty
	a_base_high_write: assert property (p_base_high_write)
		else $error("region base high not stored");

	property p_config_a_write;
		s_full_commit ##0 (ast_wa[11:8] == REGION_PAGE &&
			ast_wa[3:0] == 4'h8) |=>
			st.cfg_a[$past(ast_wa[7:4])] ==
			($past(st.w_data[15:0]) & CONFIG_A_MASK);
	endproperty
	a_config_a_write: assert property (p_config_a_write)
		else $error("config a not stored under mask");

	// status words are read-only, so any write below 0x020 but 0 fails
	property p_pending_read_only;
		s_commit ##0 (ast_wa[11:5] == 7'h00 && ast_wa != 12'h000)
			|=> S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR;
	endproperty
	a_pending_read_only: assert property (p_pending_read_only)
		else $error("write to pending word not refused");

endmodule

// *** qmr_dma_model.sv ***
// file: queue-side model that drives the per-queue pending lines
`timescale 1ns/1ns
module qmr_dma_model (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic [6:0] qidx,
	output logic [95:0]     pending
);
	logic [3:0] depth [96];
	// ----------------
	// queue depth book-keeping
	// ----------------
	// a pop on an empty queue is ignored, as the real manager would
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 96; i++) begin
				depth[i] <= 4'h0;
			end
		end else if (push) begin
			depth[qidx] <= depth[qidx] + 4'h1;
		end else if (pop && depth[qidx] != 4'h0) begin
			depth[qidx] <= depth[qidx] - 4'h1;
		end
	end
	// pending while at least one descriptor is held
	always_comb begin
		for (int i = 0; i < 96; i++) begin
			pending[i] = (depth[i] != 4'h0);
		end
	end
endmodule

// *** qmr_regs_tb.sv ***
// file: self-checking bench of the region and pending register slice
`timescale 1ns/1ns
module qmr_regs_tb;
	import qmr_pkg::*;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [1:0]  br;
		logic [31:0] rv;
		logic [1:0]  rr;
	} qmr_row_s;
	logic        clk = 0, rst_n = 0, push = 0, pop = 0;
	logic [6:0]  qidx = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, base, d;
	logic [3:0]  wstrb = 0, sel = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, inval;
	logic [1:0]  bresp, rresp, r;
	logic [95:0] pending;
	logic [15:0] link;
	logic [13:0] bytes, start;
	logic [12:0] count;
	int          miscompares = 0, checks = 0;
	int          qs [6] = '{0, 15, 16, 47, 80, 95};
	qmr_row_s    rows [9] = '{
		'{12'h000, 32'h1234beef, 4'hf, RESP_OKAY, 32'hbeef, RESP_OKAY},
		'{12'h000, 32'h1111, 4'h1, RESP_SLVERR, 32'hbeef, RESP_OKAY},
		'{12'h100, 32'ha5a5, 4'h3, RESP_OKAY, 32'ha5a5, RESP_OKAY},
		'{12'h1f4, 32'h5a5a, 4'hf, RESP_OKAY, 32'h5a5a, RESP_OKAY},
		'{12'h138, 32'hffffffff, 4'hf, RESP_OKAY, 32'h0f07, RESP_OKAY},
		'{12'h13c, 32'hffffffff, 4'hf, RESP_OKAY, 32'h3fff, RESP_OKAY},
		'{12'h018, 32'hffff, 4'hf, RESP_SLVERR, 32'h0, RESP_OKAY},
		'{12'h800, 32'h1, 4'hf, RESP_SLVERR, 32'h0, RESP_SLVERR},
		'{12'h102, 32'h7777, 4'hf, RESP_SLVERR, 32'h0, RESP_SLVERR}};

	qmr_regs dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .QUEUE_PENDING(pending), .REGION_SEL(sel),
		.LINK1_BASE_HIGH(link), .REGION_BASE(base), .DESC_BYTES(bytes),
		.DESC_CODE_RESERVED(inval), .REGION_DESC_COUNT(count),
		.REGION_START_INDEX(start));
	qmr_dma_model dma (.CLK(clk), .RST_N(rst_n), .push(push), .pop(pop),
		.qidx(qidx), .pending(pending));

	// ----------------
	// clock, reset and watchdog
	// ----------------
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
	end
	// the whole run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	// ----------------
	// shared tasks
	// ----------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	// sampling at the falling edge sees what the next rising edge sees
	task automatic wr(input logic [11:0] a, input logic [31:0] dv,
		input logic [3:0] s, output logic [1:0] rs);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= dv;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			rs = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end while (!tb);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] dv,
		output logic [1:0] rs);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			dv = rdata;
			rs = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end while (!tr);
	endtask
	task automatic look;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------
	// main sequence
	// ----------------
	initial begin
		@(posedge rst_n);
		rd(12'h13c, d, r);
		chk("reset cfg b", 32'h0, d);
		chk("reset count", 32'd32, count);
		chk("reset bytes", 32'd32, bytes);
		// table rows, write then read back
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].s, r);
			chk("bresp", rows[i].br, r);
			rd(rows[i].a, d, r);
			chk("rdata", rows[i].rv, d);
			chk("rresp", rows[i].rr, r);
		end
		chk("link high", 32'hbeef, link);
		// every size code, reserved ones included
		sel <= 4'h2;
		for (int c = 0; c < 16; c++) begin
			wr(12'h128, 32'((c << 8) | (c & 7)), 4'hf, r);
			look();
			chk("bytes", c < 9 ? 32 << c : 0, bytes);
			chk("invalid", 32'(c > 8), inval);
			chk("count", 32 << (c & 7), count);
		end
		@(posedge clk);
		sel <= 4'hf;
		look();
		chk("base r15", 32'h5a5a0000, base);
		@(posedge clk);
		sel <= 4'h3;
		look();
		chk("start r3", 32'h3fff, start);
		chk("count r3", 32'd4096, count);
		chk("bytes r3", 32'h0, bytes);
		@(posedge clk);
		sel <= 4'h0;
		look();
		chk("base r0", 32'h0000a5a5, base);
		// queues at word edges, raised then drained
		foreach (qs[i]) begin
			@(posedge clk);
			push <= 1'b1;
			qidx <= 7'(qs[i]);
			@(posedge clk);
			push <= 1'b0;
			rd(12'(4 + 4 * (qs[i] / 16)), d, r);
			chk("pending", 32'h1 << (qs[i] % 16), d);
			@(posedge clk);
			pop <= 1'b1;
			@(posedge clk);
			pop <= 1'b0;
			rd(12'(4 + 4 * (qs[i] / 16)), d, r);
			chk("drained", 32'h0, d);
		end
		// second reset in mid-run clears the stored half
		@(posedge clk);
		rst_n <= 1'b0;
		look();
		chk("link in reset", 32'h0, link);
		@(posedge clk);
		rst_n <= 1'b1;
		rd(12'h000, d, r);
		chk("link after", 32'h0, d);
		chk("count after", 32'd32, count);
		report_and_stop();
	end
endmodule
